// File: verilog/ccrb_pkg.sv
// Purpose: Shared constants for the converter configuration register bank
// Assumes: Byte-wide registers on a 15-bit serial control port address space
// Notes: Multi-byte registers place their low byte at the lowest address
package ccrb_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;

   // Serial frame layout: read flag, 15 address bits, 8 data bits
   localparam logic [4:0] CMD_BITS = 5'h10;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam logic [4:0] COUNT_ONE = 5'h01;
   localparam logic [4:0] COUNT_ZERO = 5'h00;
   localparam int READ_FLAG_POS = 15;

   // Register addresses
   localparam logic [14:0] ALIGN_CTRL_ADDR = 15'h0029;
   localparam logic [14:0] EDGE_POS_ADDR0 = 15'h002c;
   localparam logic [14:0] EDGE_POS_ADDR1 = 15'h002d;
   localparam logic [14:0] EDGE_POS_ADDR2 = 15'h002e;
   localparam logic [14:0] FULL_SCALE_ADDR_LO = 15'h0030;
   localparam logic [14:0] FULL_SCALE_ADDR_HI = 15'h0031;
   localparam logic [14:0] POWER_PROFILE_ADDR = 15'h0037;
   localparam logic [14:0] SYNTH_CTRL_ADDR = 15'h0039;
   localparam logic [14:0] TIMESTAMP_CTRL_ADDR = 15'h003b;
   localparam logic [14:0] REFOUT_CTRL_ADDR = 15'h003c;
   localparam logic [14:0] FEEDBACK_DIV_ADDR = 15'h003d;

   // Reset values
   localparam logic [7:0] ALIGN_CTRL_RESET = 8'h00;
   localparam logic [23:0] EDGE_POS_RESET = 24'h00_0000;
   localparam logic [15:0] FULL_SCALE_RESET = 16'ha000;
   localparam logic [15:0] FULL_SCALE_MIN = 16'h2000;
   localparam logic [7:0] POWER_PROFILE_RESET = 8'h4b;
   localparam logic [7:0] POWER_LOW = 8'h46;
   localparam logic [7:0] POWER_HIGH = 8'h4b;
   localparam logic [7:0] SYNTH_CTRL_RESET = 8'h00;
   localparam logic [7:0] TIMESTAMP_CTRL_RESET = 8'h00;
   localparam logic [7:0] REFOUT_CTRL_RESET = 8'h01;
   localparam logic [7:0] FEEDBACK_DIV_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Field positions
   localparam int TIMESTAMP_EN_BIT = 0;
   localparam int TIMESTAMP_LVPECL_BIT = 1;
   localparam int REFOUT_EN_BIT = 0;
   localparam int SYNTH_EN_BIT = 0;
   localparam int SYNTH_LOOP_RESET_BIT = 1;
   localparam int SECOND_DIV_MSB = 3;
   localparam int SECOND_DIV_LSB = 2;
   localparam int FIRST_DIV_MSB = 1;
   localparam int FIRST_DIV_LSB = 0;
   localparam int ALIGN_SEL_MSB = 3;

   // Divider codes and ratios
   localparam logic [1:0] DIV_CODE0 = 2'h0;
   localparam logic [1:0] DIV_CODE1 = 2'h1;
   localparam logic [1:0] DIV_CODE2 = 2'h2;
   localparam logic [2:0] FIRST_RATIO0 = 3'h5;
   localparam logic [2:0] FIRST_RATIO1 = 3'h4;
   localparam logic [2:0] FIRST_RATIO2 = 3'h3;
   localparam logic [2:0] SECOND_RATIO0 = 3'h1;
   localparam logic [2:0] SECOND_RATIO1 = 3'h2;
   localparam logic [2:0] SECOND_RATIO2 = 3'h4;
   localparam logic [2:0] RATIO_RESERVED = 3'h0;
endpackage

// File: verilog/ccrb_serial_port.sv
// Purpose: Serial control port slave turning frames into byte accesses
// Assumes: Serial pins are synchronous to clock; serial clock half period >= 4 clocks
// Notes: Mode 0 framing, MSB first, one byte per frame, select low frames the access
module ccrb_serial_port (
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_enable,
   input wire logic serial_clock,
   input wire logic serial_select_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic write_strobe,
   output logic read_strobe,
   output logic [ccrb_pkg::ADDR_W-1:0] access_address,
   output logic [ccrb_pkg::DATA_W-1:0] write_data,
   input wire logic [ccrb_pkg::DATA_W-1:0] read_data
);
   import ccrb_pkg::*;

   logic sclk_q, next_sclk_q;
   logic [15:0] shift_in, next_shift_in;
   logic [15:0] shifted;
   logic [4:0] count, next_count, count_inc;
   logic is_read, next_is_read;
   logic [7:0] out_shift, next_out_shift;
   logic rise, fall;
   logic next_serial_data_out, next_write_strobe, next_read_strobe;
   logic [ADDR_W-1:0] next_access_address;
   logic [DATA_W-1:0] next_write_data;

   always_comb begin
      rise = serial_clock & ~sclk_q;
      fall = ~serial_clock & sclk_q;
      shifted = {shift_in[14:0], serial_data_in};
      count_inc = count + COUNT_ONE;
      next_sclk_q = serial_clock;
      next_shift_in = shift_in;
      next_count = count;
      next_is_read = is_read;
      next_out_shift = out_shift;
      next_serial_data_out = serial_data_out;
      next_write_strobe = 1'b0;
      next_read_strobe = 1'b0;
      next_access_address = access_address;
      next_write_data = write_data;
      if (serial_select_n) begin
         next_count = COUNT_ZERO;
         next_serial_data_out = 1'b0;
      end else if (rise && count < FRAME_BITS) begin
         next_shift_in = shifted;
         next_count = count_inc;
         if (count_inc == CMD_BITS) begin
            next_access_address = shifted[ADDR_W-1:0];
            next_is_read = shifted[READ_FLAG_POS];
            next_read_strobe = shifted[READ_FLAG_POS];
         end
         if (count_inc == FRAME_BITS && !is_read) begin
            next_write_data = shifted[DATA_W-1:0];
            next_write_strobe = 1'b1;
         end
      end else if (fall && is_read && count >= CMD_BITS && count < FRAME_BITS) begin
         if (count == CMD_BITS) begin
            next_serial_data_out = read_data[7];
            next_out_shift = {read_data[6:0], 1'b0};
         end else begin
            next_serial_data_out = out_shift[7];
            next_out_shift = {out_shift[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_q <= 1'b0;
         shift_in <= '0;
         count <= COUNT_ZERO;
         is_read <= 1'b0;
         out_shift <= '0;
         serial_data_out <= 1'b0;
         write_strobe <= 1'b0;
         read_strobe <= 1'b0;
         access_address <= '0;
         write_data <= '0;
      end else if (clock_enable) begin
         sclk_q <= next_sclk_q;
         shift_in <= next_shift_in;
         count <= next_count;
         is_read <= next_is_read;
         out_shift <= next_out_shift;
         serial_data_out <= next_serial_data_out;
         write_strobe <= next_write_strobe;
         read_strobe <= next_read_strobe;
         access_address <= next_access_address;
         write_data <= next_write_data;
      end
   end
endmodule

// File: verilog/ccrb_register_bank.sv
// Purpose: Configuration and status registers of a multichannel converter
// Assumes: Host reaches the registers through the serial control port only
// Notes: Outputs are registered copies or decodes of the stored register fields
// Notes on behaviour
// - A read-only 24-bit status reports where the alignment strobe edge falls.
// - A 16-bit full-scale setting applies to all channels and resets to 0xA000.
// - The power-profile code selects low power at 0x46, high performance at 0x4B (reset).
// - Timestamp control bit 0 enables the timestamp input receiver and resets to zero.
// - With its enable set, the reference clock output runs whenever the synthesizer runs.
// - The reference output enable resets to one so the output comes up once the synthesizer is enabled.
// - Second divider bits 3:2 divide by 1, 2, 4 for codes 0, 1, 2; code 3 is reserved.
// - First divider bits 1:0 divide by 5, 4, 3 for codes 0, 1, 2; code 3 is reserved.
// - A 4-bit alignment delay selection chooses the strobe capture delay.
module ccrb_register_bank (
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_enable,
   input wire logic serial_clock,
   input wire logic serial_select_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   input wire logic [23:0] edge_position_value,
   input wire logic edge_position_valid,
   output logic [15:0] full_scale_setting,
   output logic [7:0] power_profile_code,
   output logic low_power_mode,
   output logic profile_reserved,
   output logic timestamp_input_enable,
   output logic timestamp_lvpecl_enable,
   output logic [3:0] alignment_delay_select,
   output logic synth_enable,
   output logic synth_loop_reset,
   output logic reference_output_active,
   output logic [2:0] first_divider_ratio,
   output logic [2:0] second_divider_ratio
);
   import ccrb_pkg::*;

   logic write_strobe, read_strobe;
   logic [ADDR_W-1:0] access_address;
   logic [DATA_W-1:0] write_data;
   logic [DATA_W-1:0] read_data, next_read_data;
   logic [23:0] edge_position, next_edge_position;
   logic [15:0] next_full_scale_setting;
   logic [7:0] align_ctrl, next_align_ctrl;
   logic [7:0] next_power_profile_code;
   logic [7:0] synth_ctrl, next_synth_ctrl;
   logic [7:0] timestamp_ctrl, next_timestamp_ctrl;
   logic [7:0] refout_ctrl, next_refout_ctrl;
   logic [7:0] feedback_div, next_feedback_div;
   logic next_low_power_mode, next_profile_reserved;
   logic next_timestamp_input_enable, next_timestamp_lvpecl_enable;
   logic [3:0] next_alignment_delay_select;
   logic next_synth_enable, next_synth_loop_reset, next_reference_output_active;
   logic [2:0] next_first_divider_ratio, next_second_divider_ratio;

   ccrb_serial_port port (
      .clock(clock),
      .rst(rst),
      .clock_enable(clock_enable),
      .serial_clock(serial_clock),
      .serial_select_n(serial_select_n),
      .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out),
      .write_strobe(write_strobe),
      .read_strobe(read_strobe),
      .access_address(access_address),
      .write_data(write_data),
      .read_data(read_data)
   );

   // Divider code to ratio; reserved code gives zero
   function automatic logic [2:0] divider_ratio(input logic [1:0] code, input logic second);
      logic [2:0] r;
      r = RATIO_RESERVED;
      case (code)
         DIV_CODE0: r = second ? SECOND_RATIO0 : FIRST_RATIO0;
         DIV_CODE1: r = second ? SECOND_RATIO1 : FIRST_RATIO1;
         DIV_CODE2: r = second ? SECOND_RATIO2 : FIRST_RATIO2;
         default: r = RATIO_RESERVED;
      endcase
      return r;
   endfunction

   function automatic logic write_hit(input logic [ADDR_W-1:0] target);
      return write_strobe && access_address == target;
   endfunction

   always_comb begin
      next_edge_position = edge_position_valid ? edge_position_value : edge_position;
      next_full_scale_setting = full_scale_setting;
      next_align_ctrl = align_ctrl;
      next_power_profile_code = power_profile_code;
      next_synth_ctrl = synth_ctrl;
      next_timestamp_ctrl = timestamp_ctrl;
      next_refout_ctrl = refout_ctrl;
      next_feedback_div = feedback_div;
      if (write_hit(FULL_SCALE_ADDR_LO)) begin
         next_full_scale_setting[7:0] = write_data;
      end
      if (write_hit(FULL_SCALE_ADDR_HI)) begin
         next_full_scale_setting[15:8] = write_data;
      end
      if (write_hit(ALIGN_CTRL_ADDR)) begin
         next_align_ctrl = write_data;
      end
      if (write_hit(POWER_PROFILE_ADDR)) begin
         next_power_profile_code = write_data;
      end
      if (write_hit(SYNTH_CTRL_ADDR)) begin
         next_synth_ctrl = write_data;
      end
      if (write_hit(TIMESTAMP_CTRL_ADDR)) begin
         next_timestamp_ctrl = write_data;
      end
      if (write_hit(REFOUT_CTRL_ADDR)) begin
         next_refout_ctrl = write_data;
      end
      if (write_hit(FEEDBACK_DIV_ADDR)) begin
         next_feedback_div = write_data;
      end
   end

   always_comb begin
      next_read_data = read_data;
      if (read_strobe) begin
         case (access_address)
            ALIGN_CTRL_ADDR: next_read_data = align_ctrl;
            EDGE_POS_ADDR0: next_read_data = edge_position[7:0];
            EDGE_POS_ADDR1: next_read_data = edge_position[15:8];
            EDGE_POS_ADDR2: next_read_data = edge_position[23:16];
            FULL_SCALE_ADDR_LO: next_read_data = full_scale_setting[7:0];
            FULL_SCALE_ADDR_HI: next_read_data = full_scale_setting[15:8];
            POWER_PROFILE_ADDR: next_read_data = power_profile_code;
            SYNTH_CTRL_ADDR: next_read_data = synth_ctrl;
            TIMESTAMP_CTRL_ADDR: next_read_data = timestamp_ctrl;
            REFOUT_CTRL_ADDR: next_read_data = refout_ctrl;
            FEEDBACK_DIV_ADDR: next_read_data = feedback_div;
            default: next_read_data = READ_UNMAPPED;
         endcase
      end
   end

   always_comb begin
      next_low_power_mode = next_power_profile_code == POWER_LOW;
      next_profile_reserved = next_power_profile_code != POWER_LOW &&
         next_power_profile_code != POWER_HIGH;
      next_timestamp_input_enable = next_timestamp_ctrl[TIMESTAMP_EN_BIT];
      next_timestamp_lvpecl_enable = next_timestamp_ctrl[TIMESTAMP_LVPECL_BIT];
      next_alignment_delay_select = next_align_ctrl[ALIGN_SEL_MSB:0];
      next_synth_enable = next_synth_ctrl[SYNTH_EN_BIT];
      next_synth_loop_reset = next_synth_ctrl[SYNTH_LOOP_RESET_BIT];
      next_reference_output_active = next_refout_ctrl[REFOUT_EN_BIT] &
         next_synth_ctrl[SYNTH_EN_BIT];
      next_first_divider_ratio =
         divider_ratio(next_feedback_div[FIRST_DIV_MSB:FIRST_DIV_LSB], 1'b0);
      next_second_divider_ratio =
         divider_ratio(next_feedback_div[SECOND_DIV_MSB:SECOND_DIV_LSB], 1'b1);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         edge_position <= EDGE_POS_RESET;
         full_scale_setting <= FULL_SCALE_RESET;
         align_ctrl <= ALIGN_CTRL_RESET;
         power_profile_code <= POWER_PROFILE_RESET;
         synth_ctrl <= SYNTH_CTRL_RESET;
         timestamp_ctrl <= TIMESTAMP_CTRL_RESET;
         refout_ctrl <= REFOUT_CTRL_RESET;
         feedback_div <= FEEDBACK_DIV_RESET;
         read_data <= READ_UNMAPPED;
         low_power_mode <= 1'b0;
         profile_reserved <= 1'b0;
         timestamp_input_enable <= TIMESTAMP_CTRL_RESET[TIMESTAMP_EN_BIT];
         timestamp_lvpecl_enable <= TIMESTAMP_CTRL_RESET[TIMESTAMP_LVPECL_BIT];
         alignment_delay_select <= ALIGN_CTRL_RESET[ALIGN_SEL_MSB:0];
         synth_enable <= SYNTH_CTRL_RESET[SYNTH_EN_BIT];
         synth_loop_reset <= SYNTH_CTRL_RESET[SYNTH_LOOP_RESET_BIT];
         reference_output_active <= 1'b0;
         first_divider_ratio <= FIRST_RATIO0;
         second_divider_ratio <= SECOND_RATIO0;
      end else if (clock_enable) begin
         edge_position <= next_edge_position;
         full_scale_setting <= next_full_scale_setting;
         align_ctrl <= next_align_ctrl;
         power_profile_code <= next_power_profile_code;
         synth_ctrl <= next_synth_ctrl;
         timestamp_ctrl <= next_timestamp_ctrl;
         refout_ctrl <= next_refout_ctrl;
         feedback_div <= next_feedback_div;
         read_data <= next_read_data;
         low_power_mode <= next_low_power_mode;
         profile_reserved <= next_profile_reserved;
         timestamp_input_enable <= next_timestamp_input_enable;
         timestamp_lvpecl_enable <= next_timestamp_lvpecl_enable;
         alignment_delay_select <= next_alignment_delay_select;
         synth_enable <= next_synth_enable;
         synth_loop_reset <= next_synth_loop_reset;
         reference_output_active <= next_reference_output_active;
         first_divider_ratio <= next_first_divider_ratio;
         second_divider_ratio <= next_second_divider_ratio;
      end
   end

   chk_edge_capture: assert property (@(posedge clock) disable iff (rst)
      clock_enable && edge_position_valid |=> edge_position == $past(edge_position_value))
      else $error("edge position not captured");
   chk_edge_readback: assert property (@(posedge clock) disable iff (rst)
      clock_enable && read_strobe && access_address == EDGE_POS_ADDR1 && !edge_position_valid
      |=> read_data == edge_position[15:8])
      else $error("edge position readback wrong");
   chk_fs_write_high: assert property (@(posedge clock) disable iff (rst)
      clock_enable && write_strobe && access_address == FULL_SCALE_ADDR_HI
      |=> full_scale_setting[15:8] == $past(write_data))
      else $error("full scale high byte not written");
   chk_fs_reset_value: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) && $past(clock_enable) |-> full_scale_setting == FULL_SCALE_RESET)
      else $error("full scale reset value wrong");
   chk_power_mode_decode: assert property (@(posedge clock) disable iff (rst)
      low_power_mode == (power_profile_code == POWER_LOW) &&
      profile_reserved == (power_profile_code != POWER_LOW && power_profile_code != POWER_HIGH))
      else $error("power profile decode wrong");
   chk_timestamp_enable: assert property (@(posedge clock) disable iff (rst)
      clock_enable && write_strobe && access_address == TIMESTAMP_CTRL_ADDR
      |=> timestamp_input_enable == $past(write_data[TIMESTAMP_EN_BIT]))
      else $error("timestamp enable not following write");
   chk_refout_gating: assert property (@(posedge clock) disable iff (rst)
      reference_output_active == (refout_ctrl[REFOUT_EN_BIT] && synth_enable))
      else $error("reference output gating wrong");
   chk_refout_reset: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) && $past(clock_enable) |-> refout_ctrl[REFOUT_EN_BIT])
      else $error("reference output enable not set after reset");
   chk_second_ratio: assert property (@(posedge clock) disable iff (rst)
      feedback_div[SECOND_DIV_MSB:SECOND_DIV_LSB] == DIV_CODE2
      |-> second_divider_ratio == SECOND_RATIO2)
      else $error("second divider ratio wrong");
   chk_first_ratio: assert property (@(posedge clock) disable iff (rst)
      feedback_div[FIRST_DIV_MSB:FIRST_DIV_LSB] == DIV_CODE0
      |-> first_divider_ratio == FIRST_RATIO0)
      else $error("first divider ratio wrong");
   chk_align_select: assert property (@(posedge clock) disable iff (rst)
      alignment_delay_select == align_ctrl[ALIGN_SEL_MSB:0])
      else $error("alignment delay select mismatch");
   chk_edge_no_write: assert property (@(posedge clock) disable iff (rst)
      clock_enable && write_strobe && access_address == EDGE_POS_ADDR0 && !edge_position_valid
      |=> $stable(edge_position))
      else $error("edge position changed by a write");
   chk_freeze_hold: assert property (@(posedge clock) disable iff (rst)
      !clock_enable |=> $stable(edge_position) && $stable(full_scale_setting))
      else $error("state changed while clock enable low");
endmodule

// File: verif/ccrb_testbench.sv
// Purpose: Self-checking bench for the converter configuration register bank
// Assumes: Serial frames with a half period of four clocks, inputs driven on falling edges
// Notes: Expected values are noted in a queue and compared by a watching process
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import ccrb_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic clock_enable = 1'b1;
   logic serial_clock = 1'b0;
   logic serial_select_n = 1'b1;
   logic serial_data_in = 1'b0;
   logic [23:0] edge_position_value = 24'h00_0000;
   logic edge_position_valid = 1'b0;
   logic serial_data_out, low_power_mode, profile_reserved, timestamp_input_enable;
   logic timestamp_lvpecl_enable, synth_enable, synth_loop_reset, reference_output_active;
   logic [15:0] full_scale_setting;
   logic [7:0] power_profile_code;
   logic [3:0] alignment_delay_select;
   logic [2:0] first_divider_ratio, second_divider_ratio;
   int fails = 0;
   int comparisons = 0;
   logic [23:0] exp_q[$];
   logic [23:0] seen_q[$];
   logic [14:0] reg_addr [9] = '{ALIGN_CTRL_ADDR, EDGE_POS_ADDR0, FULL_SCALE_ADDR_LO,
      FULL_SCALE_ADDR_HI, POWER_PROFILE_ADDR, SYNTH_CTRL_ADDR, TIMESTAMP_CTRL_ADDR,
      REFOUT_CTRL_ADDR, FEEDBACK_DIV_ADDR};
   logic [7:0] reg_reset [9] = '{8'h00, 8'h00, 8'h00, 8'ha0, 8'h4b, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [2:0] first_tab [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
   logic [2:0] second_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
   logic [23:0] edge_val;
   logic [15:0] fs_val;
   logic [7:0] code;

   ccrb_register_bank u_ccrb_register_bank (.clock(clock), .rst(rst),
      .clock_enable(clock_enable), .serial_clock(serial_clock),
      .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .edge_position_value(edge_position_value),
      .edge_position_valid(edge_position_valid), .full_scale_setting(full_scale_setting),
      .power_profile_code(power_profile_code), .low_power_mode(low_power_mode),
      .profile_reserved(profile_reserved), .timestamp_input_enable(timestamp_input_enable),
      .timestamp_lvpecl_enable(timestamp_lvpecl_enable),
      .alignment_delay_select(alignment_delay_select), .synth_enable(synth_enable),
      .synth_loop_reset(synth_loop_reset), .reference_output_active(reference_output_active),
      .first_divider_ratio(first_divider_ratio), .second_divider_ratio(second_divider_ratio));

   always #10 clock = ~clock;

   task automatic finish_test();
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Watcher takes every pending note, oldest first, on each rising clock edge
   always @(posedge clock) begin
      while (seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
   end

   task automatic expect_out(input logic [23:0] s, input logic [23:0] e);
      exp_q.push_back(e);
      seen_q.push_back(s);
   endtask

   // One frame: flag, address, data, MSB first, data sampled before each rise
   task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [23:0] f;
      f = {r, a, d};
      q = 8'h00;
      serial_select_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_data_in = f[i];
         repeat (4) @(negedge clock);
         if (i < 8) q[i] = serial_data_out;
         serial_clock = 1'b1;
         repeat (4) @(negedge clock);
         serial_clock = 1'b0;
      end
      repeat (2) @(negedge clock);
      serial_select_n = 1'b1;
      repeat (4) @(negedge clock);
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b0, a, d, q);
   endtask

   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] q;
      xfer(1'b1, a, 8'h00, q);
      expect_out(q, e);
   endtask

   task automatic chk_reset();
      expect_out(full_scale_setting, 16'ha000);
      expect_out(power_profile_code, 8'h4b);
      expect_out({low_power_mode, profile_reserved}, 2'h0);
      expect_out({timestamp_input_enable, timestamp_lvpecl_enable}, 2'h0);
      expect_out({synth_enable, synth_loop_reset, reference_output_active}, 3'h0);
      expect_out({first_divider_ratio, second_divider_ratio}, {3'h5, 3'h1});
      expect_out({alignment_delay_select, serial_data_out}, 5'h00);
      for (int i = 0; i < 9; i++) rd(reg_addr[i], reg_reset[i]);
   endtask

   initial begin
      repeat (60000) @(posedge clock);
      fails++;
      finish_test();
   end

   initial begin
      void'($urandom(40));
      repeat (3) @(negedge clock);
      rst = 1'b0;
      chk_reset();
      rd(15'h0100, 8'h00);
      // Full-scale boundaries and a random legal code above the minimum
      for (int i = 0; i < 3; i++) begin
         fs_val = (i == 0) ? 16'h2000 : (i == 1) ? 16'hffff : (16'($urandom) | 16'h2000);
         wr(FULL_SCALE_ADDR_LO, fs_val[7:0]);
         wr(FULL_SCALE_ADDR_HI, fs_val[15:8]);
         expect_out(full_scale_setting, fs_val);
         rd(FULL_SCALE_ADDR_HI, fs_val[15:8]);
      end
      // Power codes: low, high, then a reserved one
      for (int i = 0; i < 3; i++) begin
         code = (i == 0) ? 8'h46 : (i == 1) ? 8'h4b : 8'($urandom);
         if (i == 2 && (code == 8'h46 || code == 8'h4b)) code = 8'h00;
         wr(POWER_PROFILE_ADDR, code);
         expect_out({power_profile_code, low_power_mode, profile_reserved},
            {code, i == 0, i == 2});
      end
      wr(TIMESTAMP_CTRL_ADDR, 8'h01);
      expect_out({timestamp_input_enable, timestamp_lvpecl_enable}, 2'h2);
      wr(TIMESTAMP_CTRL_ADDR, 8'h02);
      expect_out({timestamp_input_enable, timestamp_lvpecl_enable}, 2'h1);
      wr(ALIGN_CTRL_ADDR, 8'h0a);
      expect_out(alignment_delay_select, 4'ha);
      // Reference output follows its enable only while the synthesizer runs
      wr(SYNTH_CTRL_ADDR, 8'h01);
      expect_out(reference_output_active, 1'b1);
      wr(REFOUT_CTRL_ADDR, 8'h00);
      expect_out(reference_output_active, 1'b0);
      wr(REFOUT_CTRL_ADDR, 8'h01);
      wr(SYNTH_CTRL_ADDR, 8'h02);
      expect_out({synth_enable, synth_loop_reset, reference_output_active}, 3'h2);
      for (int c = 0; c < 16; c++) begin
         wr(FEEDBACK_DIV_ADDR, 8'(c));
         expect_out(first_divider_ratio, first_tab[c % 4]);
         expect_out(second_divider_ratio, second_tab[c / 4]);
      end
      // Edge status is captured from hardware and ignores writes
      edge_val = 24'($urandom);
      edge_position_value = edge_val;
      edge_position_valid = 1'b1;
      @(negedge clock);
      edge_position_valid = 1'b0;
      edge_position_value = ~edge_val;
      wr(EDGE_POS_ADDR0, ~edge_val[7:0]);
      rd(EDGE_POS_ADDR0, edge_val[7:0]);
      rd(EDGE_POS_ADDR1, edge_val[15:8]);
      rd(EDGE_POS_ADDR2, edge_val[23:16]);
      // Clock enable low freezes capture
      clock_enable = 1'b0;
      edge_position_valid = 1'b1;
      repeat (3) @(negedge clock);
      edge_position_valid = 1'b0;
      clock_enable = 1'b1;
      rd(EDGE_POS_ADDR1, edge_val[15:8]);
      // Second reset in mid-run
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      chk_reset();
      repeat (2) @(negedge clock);
      finish_test();
   end
endmodule
